// ===== verilog/power_analog_ctrl_regs.svh
// register indices, field positions, reset values and timing counts
// assumes a 10 MHz system clock and a word-wide register bus
`ifndef POWER_ANALOG_CTRL_REGS_SVH
`define POWER_ANALOG_CTRL_REGS_SVH

// register indices, byte address is four times the index
`define IDX_DESAT_CONTROL 12'h190
`define IDX_OFFSET_ADJUST 12'h191
`define IDX_BLANKING 12'h192
`define IDX_SLOPE 12'h193
`define IDX_DEADTIME_CODE 12'h194
`define IDX_PERIPH_ENABLE 12'h195
`define IDX_DESAT_TRIM 12'h196
`define IDX_DESAT_FLAG 12'h197

// control register fields
`define BIT_INPUT_SELECT 7
`define BIT_WATCHDOG_EN 6
`define BIT_RESERVED 5
`define BIT_INVERT 4
`define BIT_OUT_ENABLE 3
`define BIT_STATUS 2
`define BIT_RISE_EN 1
`define BIT_FALL_EN 0

// other fields
`define BIT_SLOPE_BYPASS 6
`define BIT_PRI_BYPASS 1
`define BIT_SEC_BYPASS 0
`define BIT_FLAG 0

// reset values
`define RST_CONTROL 8'h00
`define RST_OFFSET 4'h0
`define RST_BLANKING 2'h0
`define RST_SLOPE 7'h00
`define RST_DEADTIME 8'h00
`define RST_PERIPH 2'h0
`define RST_TRIM 8'h00

// timing
`define CLK_MHZ 10
`define BLANK_NS_1 50
`define BLANK_NS_2 100
`define BLANK_NS_3 200
`define DEAD_STEP_NS 16
`define NS_TO_CYC(ns) ((((ns) * `CLK_MHZ) + 999) / 1000)

`endif

// ===== verilog/power_analog_ctrl_pkg.sv
// types shared by the analog control register bank
// state codes are literals here, the constants header holds the other numeric values
package power_analog_ctrl_pkg;
  typedef enum logic [1:0] {
    BLANK_IDLE = 2'h0,
    BLANK_ACTIVE = 2'h1
  } blank_state_type;
  typedef logic [7:0] reg_byte_type;
endpackage : power_analog_ctrl_pkg

// ===== verilog/power_analog_ctrl_regs.sv
// register bank and digital glue for the converter analog front end
// assumes a single 10 MHz clock, synchronous inputs except the comparator
`timescale 1ns/10ps
`default_nettype none
`include "power_analog_ctrl_regs.svh"

// turn-on delay for one low-side gate drive, turn-off follows on the next clock
module gate_turn_on_delay #(
  parameter int unsigned CODE_WIDTH = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // delay settings
  input wire logic [CODE_WIDTH-1:0] code,
  input wire logic bypass,
  // drive request and gate
  input wire logic drive_req,
  output logic gate_drive
);

  logic [CODE_WIDTH:0] steps;
  logic [2:0] delay;
  logic [2:0] cnt_r;
  logic gate_r;

  assign steps = {1'b0, code} + {{CODE_WIDTH{1'b0}}, 1'b1};
  // (code+1) x 16 ns, rounded up to cycles
  assign delay = 3'(`NS_TO_CYC(32'(steps) * `DEAD_STEP_NS));

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cnt_r <= 3'h0;
      gate_r <= 1'b0;
    end else if (!drive_req) begin
      cnt_r <= 3'h0;
      gate_r <= 1'b0;
    end else if (bypass) begin
      gate_r <= 1'b1;
    end else if (!gate_r) begin
      if (cnt_r + 3'h1 >= delay) begin
        gate_r <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 3'h1;
      end
    end
  end

  assign gate_drive = gate_r;

endmodule : gate_turn_on_delay

module power_analog_ctrl_regs (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // avalon-mm slave
  input wire logic [11:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // desaturation comparator
  input wire logic desat_comp_raw,
  input wire logic desat_watchdog,
  output logic desat_input_select,
  output logic desat_pwm_terminate,
  output logic desat_pwm_reset,
  output logic [7:0] desat_offset_trim,
  output logic desat_irq_flag,
  // current sense and slope
  input wire logic current_sense_trip,
  output logic current_trip_qualified,
  output logic [3:0] offset_adjust_code,
  output logic slope_bypass,
  output logic [5:0] slope_rate_code,
  // gate drivers
  input wire logic primary_drive_req,
  input wire logic secondary_drive_req,
  output logic primary_gate_drive,
  output logic secondary_gate_drive
);

  logic waitrequest_r;
  logic [31:0] readdata_r;
  logic [7:0] control_r;
  logic [3:0] offset_r;
  logic [1:0] blanking_r;
  logic [6:0] slope_r;
  logic [7:0] deadtime_r;
  logic [1:0] periph_r;
  logic [7:0] trim_r;
  logic flag_r;
  logic sync1_r;
  logic sync2_r;
  logic status_r;
  logic status_prev_r;
  logic terminate_r;
  logic wd_reset_r;
  logic trip_r;
  logic [11:0] index;
  logic wr_take;
  logic rd_take;
  logic status_nxt;
  logic flag_set;
  logic flag_clr;
  logic [7:0] rd_byte;

  assign index = {2'h0, address[11:2]};
  assign wr_take = write & ~waitrequest_r & byteenable[0];
  assign rd_take = read & waitrequest_r;

  // bus handshake: one wait cycle per access
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      waitrequest_r <= 1'b1;
    end else begin
      waitrequest_r <= ~((read | write) & waitrequest_r);
    end
  end

  always_comb begin
    case (index)
      `IDX_DESAT_CONTROL: rd_byte = {control_r[7:3], status_r, control_r[1:0]};
      `IDX_OFFSET_ADJUST: rd_byte = {4'h0, offset_r};
      `IDX_BLANKING: rd_byte = {6'h00, blanking_r};
      `IDX_SLOPE: rd_byte = {1'b0, slope_r};
      `IDX_DEADTIME_CODE: rd_byte = deadtime_r;
      `IDX_PERIPH_ENABLE: rd_byte = {6'h00, periph_r};
      `IDX_DESAT_TRIM: rd_byte = trim_r;
      `IDX_DESAT_FLAG: rd_byte = {7'h00, flag_r};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      readdata_r <= 32'h0000_0000;
    end else if (rd_take) begin
      readdata_r <= {24'h00_0000, rd_byte};
    end
  end

  // control register, written status bit is stored but reads return status_r
  // reserved bit held only
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      control_r <= `RST_CONTROL;
    end else if (wr_take && index == `IDX_DESAT_CONTROL) begin
      control_r <= writedata[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      offset_r <= `RST_OFFSET;
    end else if (wr_take && index == `IDX_OFFSET_ADJUST) begin
      offset_r <= writedata[3:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      blanking_r <= `RST_BLANKING;
    end else if (wr_take && index == `IDX_BLANKING) begin
      blanking_r <= writedata[1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      slope_r <= `RST_SLOPE;
    end else if (wr_take && index == `IDX_SLOPE) begin
      slope_r <= writedata[6:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      deadtime_r <= `RST_DEADTIME;
    end else if (wr_take && index == `IDX_DEADTIME_CODE) begin
      deadtime_r <= writedata[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      periph_r <= `RST_PERIPH;
    end else if (wr_take && index == `IDX_PERIPH_ENABLE) begin
      periph_r <= writedata[1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      trim_r <= `RST_TRIM;
    end else if (wr_take && index == `IDX_DESAT_TRIM) begin
      trim_r <= writedata[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= desat_comp_raw;
      sync2_r <= sync1_r;
    end
  end

  assign status_nxt = sync2_r ^ control_r[`BIT_INVERT];

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      status_r <= 1'b0;
      status_prev_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      status_prev_r <= status_r;
    end
  end

  assign flag_set = (control_r[`BIT_RISE_EN] & status_r & ~status_prev_r)
                  | (control_r[`BIT_FALL_EN] & ~status_r & status_prev_r);
  assign flag_clr = wr_take && index == `IDX_DESAT_FLAG && writedata[`BIT_FLAG];

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      flag_r <= 1'b0;
    end else if (flag_set) begin
      flag_r <= 1'b1;
    end else if (flag_clr) begin
      flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      terminate_r <= 1'b0;
      wd_reset_r <= 1'b0;
    end else begin
      terminate_r <= control_r[`BIT_OUT_ENABLE] & status_r;
      wd_reset_r <= control_r[`BIT_WATCHDOG_EN] & desat_watchdog;
    end
  end

  // leading edge blanking
  power_analog_ctrl_pkg::blank_state_type blank_state_r;
  logic [1:0] blank_cnt_r;
  logic [1:0] blank_len;
  logic pri_prev_r;
  logic pri_turn_on;

  always_comb begin
    case (blanking_r)
      2'h1: blank_len = 2'(`NS_TO_CYC(`BLANK_NS_1));
      2'h2: blank_len = 2'(`NS_TO_CYC(`BLANK_NS_2));
      2'h3: blank_len = 2'(`NS_TO_CYC(`BLANK_NS_3));
      default: blank_len = 2'h0;
    endcase
  end

  // turn-on edge that opens a window
  assign pri_turn_on = primary_drive_req & ~pri_prev_r & (blank_len != 2'h0);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      blank_state_r <= power_analog_ctrl_pkg::BLANK_IDLE;
      blank_cnt_r <= 2'h0;
      pri_prev_r <= 1'b0;
    end else begin
      pri_prev_r <= primary_drive_req;
      case (blank_state_r)
        power_analog_ctrl_pkg::BLANK_IDLE: begin
          if (pri_turn_on) begin
            blank_state_r <= power_analog_ctrl_pkg::BLANK_ACTIVE;
            blank_cnt_r <= blank_len - 2'h1;
          end
        end
        power_analog_ctrl_pkg::BLANK_ACTIVE: begin
          if (blank_cnt_r == 2'h0) begin
            blank_state_r <= power_analog_ctrl_pkg::BLANK_IDLE;
          end else begin
            blank_cnt_r <= blank_cnt_r - 2'h1;
          end
        end
        default: blank_state_r <= power_analog_ctrl_pkg::BLANK_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      trip_r <= 1'b0;
    end else begin
      trip_r <= current_sense_trip
              & (blank_state_r == power_analog_ctrl_pkg::BLANK_IDLE)
              & ~pri_turn_on;
    end
  end

  // primary dead timer, own code and bypass
  gate_turn_on_delay #(
    .CODE_WIDTH(4)
  ) primary_delay (
    .clk_sys(clk_sys),
    .reset(reset),
    .code(deadtime_r[7:4]),
    .bypass(periph_r[`BIT_PRI_BYPASS]),
    .drive_req(primary_drive_req),
    .gate_drive(primary_gate_drive)
  );

  // secondary dead timer, own code and bypass
  gate_turn_on_delay #(
    .CODE_WIDTH(4)
  ) secondary_delay (
    .clk_sys(clk_sys),
    .reset(reset),
    .code(deadtime_r[3:0]),
    .bypass(periph_r[`BIT_SEC_BYPASS]),
    .drive_req(secondary_drive_req),
    .gate_drive(secondary_gate_drive)
  );

  assign readdata = readdata_r;
  assign waitrequest = waitrequest_r;
  assign desat_input_select = control_r[`BIT_INPUT_SELECT];
  assign desat_pwm_terminate = terminate_r;
  assign desat_pwm_reset = wd_reset_r;
  // trim register as written by firmware
  assign desat_offset_trim = trim_r;
  assign desat_irq_flag = flag_r;
  assign current_trip_qualified = trip_r;
  assign offset_adjust_code = offset_r;
  assign slope_bypass = slope_r[`BIT_SLOPE_BYPASS];
  assign slope_rate_code = slope_r[5:0];

endmodule : power_analog_ctrl_regs

`default_nettype wire

// ===== test/power_analog_ctrl_props.sv
// checker on the register bank ports
// assumes it is bound to every bank instance
`timescale 1ns/10ps
`default_nettype none
module power_analog_ctrl_props (
  // bus
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [11:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // analog side
  input wire logic desat_watchdog,
  input wire logic desat_input_select,
  input wire logic desat_pwm_reset,
  input wire logic current_sense_trip,
  input wire logic current_trip_qualified,
  input wire logic slope_bypass,
  input wire logic [5:0] slope_rate_code,
  input wire logic primary_drive_req,
  input wire logic primary_gate_drive,
  // register outputs
  input wire logic [7:0] desat_offset_trim,
  input wire logic [3:0] offset_adjust_code,
  input wire logic desat_irq_flag
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic wr_ok;
  assign wr_ok = write && byteenable[0] && !waitrequest;
  logic flag_clr_req;
  logic wd_en_r;
  assign flag_clr_req = wr_ok && address[11:2] == 10'h197 && writedata[0];
  // watchdog enable as last written
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wd_en_r <= 1'b0;
    end else if (wr_ok && address[11:2] == 10'h190) begin
      wd_en_r <= writedata[6];
    end
  end
  sel_write_a: assert property (wr_ok && address[11:2] == 10'h190
    |=> desat_input_select == $past(writedata[7])) else $error("input select wrong");
  wd_reset_a: assert property (
    desat_pwm_reset == ($past(wd_en_r) && $past(desat_watchdog)))
    else $error("pwm reset not gated by watchdog enable");
  trip_pass_a: assert property (current_trip_qualified |-> $past(current_sense_trip))
    else $error("trip without sense");
  slope_write_a: assert property (wr_ok && address[11:2] == 10'h193 |=>
    {slope_bypass, slope_rate_code} == $past(writedata[6:0])) else $error("slope wrong");
  upper_zero_a: assert property (read && !waitrequest && address[11:2] == 10'h192
    |-> readdata[7:2] == 6'h00) else $error("blanking upper bits set");
  answer_bound_a: assert property ((read || write) && waitrequest
    |-> ##[1:2] !waitrequest) else $error("access not answered");
  wait_stands_a: assert property (!waitrequest |=> waitrequest)
    else $error("answer held too long");
  gate_delay_a: assert property ($rose(primary_gate_drive) |-> $past(primary_drive_req))
    else $error("gate rose without request");
  gate_off_a: assert property (!primary_drive_req |=> !primary_gate_drive)
    else $error("gate held after request dropped");
  flag_hold_a: assert property ($fell(desat_irq_flag) |-> $past(flag_clr_req))
    else $error("flag dropped without clear");
  trim_write_a: assert property (wr_ok && address[11:2] == 10'h196
    |=> desat_offset_trim == $past(writedata[7:0])) else $error("trim wrong");
  offset_write_a: assert property (wr_ok && address[11:2] == 10'h191
    |=> offset_adjust_code == $past(writedata[3:0])) else $error("offset code wrong");
endmodule : power_analog_ctrl_props
bind power_analog_ctrl_regs power_analog_ctrl_props checker_i (.clk_sys, .reset, .address,
  .read, .write, .writedata, .byteenable, .readdata, .waitrequest, .desat_watchdog,
  .desat_input_select, .desat_pwm_reset, .current_sense_trip, .current_trip_qualified,
  .slope_bypass, .slope_rate_code, .primary_drive_req, .primary_gate_drive,
  .desat_offset_trim, .offset_adjust_code, .desat_irq_flag);
`default_nettype wire

// ===== test/power_stage_model.sv
// power stage stand-in: comparator, watchdog and current trip
// assumes the bench sets the wanted levels
`timescale 1ns/10ps
`default_nettype none
module power_stage_model (
  // wanted levels
  input wire logic comp,
  input wire logic wd,
  input wire logic tl,
  // towards the bank
  output wire logic desat_comp_raw,
  output wire logic desat_watchdog,
  output wire logic current_sense_trip
);
  // comparator settles unrelated to the clock
  assign #37 desat_comp_raw = comp;
  assign desat_watchdog = wd;
  assign current_sense_trip = tl;
endmodule : power_stage_model
`default_nettype wire

// ===== test/power_analog_ctrl_regs_test.sv
// bench for the analog control register bank
// assumes the bank, its checker and the stage model
`timescale 1ns/10ps
`default_nettype none
module power_analog_ctrl_regs_test;
  logic clk_sys = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0;
  logic [11:0] address = 12'h000;
  logic [31:0] writedata = 32'h00000000, readdata;
  logic [3:0] byteenable = 4'h0;
  logic waitrequest, raw, wdog, trip, prst, pg, sg, flag, qtrip, term;
  logic comp = 1'b0, wd = 1'b0, tl = 1'b0, preq = 1'b0, sreq = 1'b0;
  logic [7:0] expq[$], d, m[8] = '{8'h0F, 8'h03, 8'h7F, 8'hFF, 8'h03, 8'hFF, 8'h00, 8'h00};
  int fails = 0, check_count = 0;
  always #50 clk_sys = ~clk_sys;
  power_analog_ctrl_regs DUT (.clk_sys, .reset, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .desat_comp_raw(raw), .desat_watchdog(wdog),
    .desat_input_select(), .desat_pwm_terminate(term), .desat_pwm_reset(prst),
    .desat_offset_trim(), .desat_irq_flag(flag), .current_sense_trip(trip),
    .current_trip_qualified(qtrip), .offset_adjust_code(), .slope_bypass(), .slope_rate_code(),
    .primary_drive_req(preq), .secondary_drive_req(sreq), .primary_gate_drive(pg),
    .secondary_gate_drive(sg));
  power_stage_model stage (.comp, .wd, .tl, .desat_comp_raw(raw), .desat_watchdog(wdog),
    .current_sense_trip(trip));
  task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] v);
    @(posedge clk_sys);
    address <= {idx, 2'b00};
    writedata <= {24'h000000, v};
    byteenable <= 4'h1;
    if (wr) write <= 1'b1; else read <= 1'b1;
    do @(posedge clk_sys); while (waitrequest !== 1'b0);
    write <= 1'b0;
    read <= 1'b0;
  endtask : bus
  task automatic rd(input logic [9:0] idx, input logic [7:0] e);
    expq.push_back(e);
    bus(1'b0, idx, 8'h00);
  endtask : rd
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  always @(posedge clk_sys) begin
    if (read && waitrequest === 1'b0) check("readdata", expq.pop_front(), readdata[7:0]);
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    complete_run();
  end
  initial begin
    d = $urandom(32'hADE28BC4);
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    for (int i = 0; i < 9; i++) rd(10'h190 + i, 8'h00);
    $display("reset values done");
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      bus(1'b1, 10'h191 + i, d);
      rd(10'h191 + i, d & m[i]);
    end
    d = $urandom;
    bus(1'b1, 10'h190, d);
    rd(10'h190, (d & 8'hFB) | {5'h00, d[4], 2'h0});
    $display("readback done");
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 10'h190, {4'h0, i[2], 1'b0, i[2:1]});
      bus(1'b1, 10'h197, 8'h01);
      comp <= ~comp;
      repeat (6) @(posedge clk_sys);
      @(negedge clk_sys);
      check("desat_irq_flag", {7'h00, comp ? i[2] : i[1]}, {7'h00, flag});
      check("desat_pwm_terminate", {7'h00, i[2] & comp}, {7'h00, term});
      rd(10'h197, {7'h00, comp ? i[2] : i[1]});
      rd(10'h190, {4'h0, i[2], comp, i[2:1]});
    end
    bus(1'b1, 10'h197, 8'h01);
    rd(10'h197, 8'h00);
    $display("flag edges done");
    for (int w = 0; w < 2; w++) begin
      bus(1'b1, 10'h190, {1'b0, w[0], 6'h00});
      wd <= 1'b1;
      @(posedge clk_sys);
      @(negedge clk_sys);
      check("desat_pwm_reset", {7'h00, w[0]}, {7'h00, prst});
      @(posedge clk_sys);
      wd <= 1'b0;
    end
    $display("watchdog done");
    bus(1'b1, 10'h192, 8'h03);
    bus(1'b1, 10'h194, 8'hF0);
    bus(1'b1, 10'h195, 8'h00);
    @(posedge clk_sys);
    preq <= 1'b1;
    sreq <= 1'b1;
    tl <= 1'b1;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    check("gate drives", 8'h01, {6'h00, pg, sg});
    check("current_trip_qualified", 8'h00, {7'h00, qtrip});
    @(posedge clk_sys);
    @(negedge clk_sys);
    check("gate drives", 8'h03, {6'h00, pg, sg});
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    check("current_trip_qualified", 8'h01, {7'h00, qtrip});
    @(posedge clk_sys);
    preq <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    check("gate drives", 8'h01, {6'h00, pg, sg});
    bus(1'b1, 10'h195, 8'h02);
    preq <= 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    check("gate drives", 8'h03, {6'h00, pg, sg});
    $display("dead time done");
    d = 8'h00;
    bus(1'b1, 10'h196, d);
    do begin
      d = d + 8'h01;
      bus(1'b1, 10'h196, d);
      rd(10'h196, d);
    end while (d != 8'h03 && d != 8'hFF);
    $display("sweep done");
    repeat (4) @(posedge clk_sys);
    complete_run();
  end
endmodule : power_analog_ctrl_regs_test
`default_nettype wire
